// [hw/pnc_core.sv]
`timescale 1ns/1ns
module pnc_core
    import pnc_pkg::*;
#(
    parameter int source_count_param = MAX_SOURCES  // built sources, 2..255
) (
    input  wire logic                          clk_i,     // core clock
    input  wire logic                          rst_i,     // async reset, high
    input  wire logic                          ce_i,      // clock enable
    input  wire logic [source_count_param:1]   src_req_i, // source requests, id 1..N
    input  wire pnc_mm_req_t                   mm_req_i,  // memory-mapped access
    output pnc_mm_rsp_t                        mm_rsp_o,  // memory-mapped answer
    input  wire pnc_csr_req_t                  csr_req_i, // register-port access
    output pnc_csr_rsp_t                       csr_rsp_o, // register-port answer
    input  wire logic                          take_i,    // core takes interrupt
    input  wire logic                          mret_i,    // core returns
    input  wire logic                          mie_wr_i,  // software writes enable
    input  wire logic                          mie_wdata_i, // enable value
    output logic                               mie_o,     // global enable state
    output logic                               ext_pend_o, // pending above threshold
    output logic                               ext_irq_o  // request to the core
);
    localparam int NS = source_count_param;

    typedef struct packed {
        logic                priord;
        logic [NS:1][3:0]    prio;     // normalised: higher wins, 0 never
        logic [NS:1]         en;
        logic [NS:1]         req_s;
        logic [NS:1][3:0]    gated;
        logic [ID_W-1:0]     win_id;
        logic [3:0]          win_pri;
        logic                irq_pend;
        logic [3:0]          thresh;
        logic [3:0]          curpl;
        logic [BASE_W-1:0]   vbase;
        logic [ID_W-1:0]     claim_id;
        logic [3:0]          claim_pri;
        logic                mie;
        logic                mpie;
        pnc_mm_rsp_t         mm;
        pnc_csr_rsp_t        csr;
    } pnc_state_t;

    pnc_state_t s_reg;
    pnc_state_t s_next;

    // priority seen by software vs. stored form; reverse order flips both ways
    function automatic logic [3:0] pnc_flip(input logic [3:0] v, input logic ord);
        pnc_flip = v ^ {PRIO_W{ord}};
    endfunction : pnc_flip

    // decode and winner search, all in one pass
    always_comb begin
        logic [255:0]      pvec;
        logic [ID_W-1:0]   best_id;
        logic [3:0]        best_pri;
        logic [3:0]        eff_thr;
        logic [ID_W-1:0]   idx;
        logic [2:0]        wsel;
        logic              mm_ok;
        logic              is_prio;
        logic              is_en;
        logic              is_pend;
        logic              is_cfg;
        logic [31:0]       rd;
        pvec     = '0;
        best_id  = '0;
        best_pri = PRIO_NEVER;
        eff_thr  = '0;
        idx      = mm_req_i.addr[ID_W+1:2];
        wsel     = mm_req_i.addr[4:2];
        mm_ok    = 1'b0;
        is_prio  = 1'b0;
        is_en    = 1'b0;
        is_pend  = 1'b0;
        is_cfg   = 1'b0;
        rd       = '0;
        s_next   = s_reg;

        // stage 1: sample requests
        s_next.req_s = src_req_i;
        // stage 2: gate each level with its enable and pending state
        for (int i = 1; i <= NS; i++) begin
            s_next.gated[i] = (s_reg.req_s[i] && s_reg.en[i]) ? s_reg.prio[i] : PRIO_NEVER;
        end
        // stage 3: strict compare keeps the lowest id on a tie
        for (int i = 1; i <= NS; i++) begin
            if (s_reg.gated[i] > best_pri) begin
                best_pri = s_reg.gated[i];
                best_id  = ID_W'(i);
            end
        end
        s_next.win_id  = best_id;
        s_next.win_pri = best_pri;
        // stage 4: threshold is the higher of both limits
        eff_thr = (s_reg.thresh > s_reg.curpl) ? s_reg.thresh : s_reg.curpl;
        s_next.irq_pend = (s_reg.win_pri > eff_thr);

        // memory-mapped port, word-sized and aligned only
        s_next.mm = '0;
        if (mm_req_i.valid) begin
            mm_ok = (mm_req_i.size == SIZE_WORD) && (mm_req_i.addr[1:0] == 2'h0);
            if (!mm_ok) begin
                s_next.mm.load_fault  = !mm_req_i.write;
                s_next.mm.store_fault = mm_req_i.write;
            end else begin
                s_next.mm.ack = 1'b1;
                is_prio = (mm_req_i.addr[14:REGION_LSB] == OFS_PRIO[14:REGION_LSB])
                          && (idx != '0) && (32'(idx) <= NS);
                is_en   = (mm_req_i.addr[14:REGION_LSB] == OFS_EN[14:REGION_LSB])
                          && (idx != '0) && (32'(idx) <= NS);
                is_pend = (mm_req_i.addr[14:5] == OFS_PEND[14:5]);
                is_cfg  = (mm_req_i.addr == OFS_CFG);
                pvec[NS:1] = s_reg.req_s;  // bit 0 stays zero
                // unmatched addresses fall through: zero read, write dropped
                if (is_prio) begin
                    rd[3:0] = pnc_flip(s_reg.prio[idx], s_reg.priord);
                    if (mm_req_i.write) begin
                        s_next.prio[idx] = pnc_flip(mm_req_i.wdata[3:0], s_reg.priord);
                    end
                end else if (is_en) begin
                    rd[0] = s_reg.en[idx];
                    if (mm_req_i.write) begin
                        s_next.en[idx] = mm_req_i.wdata[0];
                    end
                end else if (is_pend) begin
                    rd = pvec[32*wsel +: 32];  // read only
                end else if (is_cfg) begin
                    rd[CFG_ORD_BIT] = s_reg.priord;
                    if (mm_req_i.write) begin
                        s_next.priord = mm_req_i.wdata[CFG_ORD_BIT];
                    end
                end
                s_next.mm.rdata = mm_req_i.write ? 32'h0000_0000 : rd;
            end
        end

        // register port
        s_next.csr = '0;
        if (csr_req_i.valid) begin
            s_next.csr.ack = 1'b1;
            unique case (csr_req_i.addr)
                CSR_VBASE: begin
                    s_next.csr.rdata[31:BASE_LSB] = s_reg.vbase;
                    if (csr_req_i.write) begin
                        s_next.vbase = csr_req_i.wdata[31:BASE_LSB];
                    end
                end
                CSR_THRESH: begin
                    s_next.csr.rdata[3:0] = pnc_flip(s_reg.thresh, s_reg.priord);
                    if (csr_req_i.write) begin
                        s_next.thresh = pnc_flip(csr_req_i.wdata[3:0], s_reg.priord);
                    end
                end
                CSR_HPTR: begin
                    s_next.csr.rdata = {s_reg.vbase, s_reg.claim_id, 2'h0};
                end
                CSR_CAPTURE: begin
                    if (csr_req_i.write) begin
                        // both from the same registered winner, so they always match
                        s_next.claim_id  = s_reg.win_id;
                        s_next.claim_pri = s_reg.win_pri;
                    end
                end
                CSR_CLPRIO: begin
                    s_next.csr.rdata[3:0] = pnc_flip(s_reg.claim_pri, s_reg.priord);
                end
                CSR_CURPRIO: begin
                    s_next.csr.rdata[3:0] = pnc_flip(s_reg.curpl, s_reg.priord);
                    if (csr_req_i.write) begin
                        s_next.curpl = pnc_flip(csr_req_i.wdata[3:0], s_reg.priord);
                    end
                end
                default: begin
                    s_next.csr.rdata = 32'h0000_0000;  // unknown address reads zero
                end
            endcase
        end

        // hart enable state: taking wins over return and software write
        if (take_i) begin
            s_next.mpie = s_reg.mie;
            s_next.mie  = 1'b0;
        end else if (mret_i) begin
            s_next.mie  = s_reg.mpie;
            s_next.mpie = 1'b1;
        end else if (mie_wr_i) begin
            s_next.mie = mie_wdata_i;
        end
    end

    // single state register; clock enable freezes everything
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg        <= '0;
            s_reg.priord <= CFG_RESET;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    // outputs; the request is masked by the hart's own enable
    assign mm_rsp_o   = s_reg.mm;
    assign csr_rsp_o  = s_reg.csr;
    assign mie_o      = s_reg.mie;
    assign ext_pend_o = s_reg.irq_pend;
    assign ext_irq_o  = s_reg.irq_pend && s_reg.mie;
endmodule : pnc_core

// [hw/pnc_pkg.sv]
package pnc_pkg;
    // memory-mapped offsets inside the 32KB window
    localparam logic [14:0] OFS_PRIO     = 15'h0000;
    localparam logic [14:0] OFS_PEND     = 15'h1000;
    localparam logic [14:0] OFS_EN       = 15'h2000;
    localparam logic [14:0] OFS_CFG      = 15'h3000;
    localparam int          REGION_LSB   = 10;       // priority and enable regions each span 1KB
    localparam int          PEND_WORDS   = 8;
    localparam logic [1:0]  SIZE_WORD    = 2'h2;
    localparam int          CFG_ORD_BIT  = 0;
    localparam logic        CFG_RESET    = 1'h0;
    localparam int          PRIO_W       = 4;
    localparam logic [3:0]  PRIO_RESET   = 4'h0;
    localparam logic [3:0]  PRIO_NEVER   = 4'h0;     // normalised form
    localparam int          ID_W         = 8;
    localparam int          BASE_W       = 22;
    localparam int          BASE_LSB     = 10;
    localparam int          MAX_SOURCES  = 255;
    localparam int          MIN_SOURCES  = 2;
    localparam int          PIPE_CYCLES  = 4;
    // register-port addresses
    localparam logic [11:0] CSR_VBASE    = 12'h0BC8;
    localparam logic [11:0] CSR_THRESH   = 12'h0BC9;
    localparam logic [11:0] CSR_HPTR     = 12'h0BCA;
    localparam logic [11:0] CSR_CAPTURE  = 12'h0BCB;
    localparam logic [11:0] CSR_CLPRIO   = 12'h0BCC;
    localparam logic [11:0] CSR_CURPRIO  = 12'h0BCD;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [14:0] addr;
        logic [1:0]  size;
        logic [31:0] wdata;
    } pnc_mm_req_t;

    typedef struct packed {
        logic        ack;
        logic        load_fault;
        logic        store_fault;
        logic [31:0] rdata;
    } pnc_mm_rsp_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } pnc_csr_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } pnc_csr_rsp_t;
endpackage : pnc_pkg

// [sim/pnc_checker.sv]
`timescale 1ns/1ns
module pnc_checker
    import pnc_pkg::*;
#(
    parameter int source_count_param = MAX_SOURCES // built sources
) (
    input wire logic         clk_i,      // clock
    input wire logic         rst_i,      // reset
    input wire logic         ce_i,       // enable
    input wire pnc_mm_req_t  mm_req_i,   // mm request
    input wire pnc_mm_rsp_t  mm_rsp_o,   // mm answer
    input wire pnc_csr_req_t csr_req_i,  // csr request
    input wire pnc_csr_rsp_t csr_rsp_o,  // csr answer
    input wire logic         take_i,     // take
    input wire logic         mret_i,     // return
    input wire logic         mie_o,      // enable
    input wire logic         ext_pend_o, // pending
    input wire logic         ext_irq_o   // irq
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // request to core only when pending and enabled
    a_irq_gating: assert property (ext_irq_o == (ext_pend_o && mie_o))
        else $error("irq differs from pend and enable");
    a_take_clears: assert property (ce_i && take_i |=> !mie_o)
        else $error("enable kept after take");
    // take, one quiet cycle, then return: the enable saved by the take comes back
    a_mret_restore: assert property (ce_i && take_i && mie_o ##1 ce_i && !take_i
        && !mret_i ##1 ce_i && mret_i && !take_i |=> mie_o) else $error("return lost enable");
    // narrow loads and misaligned stores fault instead of acking
    a_load_fault: assert property (ce_i && mm_req_i.valid && !mm_req_i.write
        && mm_req_i.size != SIZE_WORD |=> mm_rsp_o.load_fault && !mm_rsp_o.ack)
        else $error("narrow load not faulted");
    a_store_fault: assert property (ce_i && mm_req_i.valid && mm_req_i.write
        && mm_req_i.addr[1:0] != 2'h0 |=> mm_rsp_o.store_fault && !mm_rsp_o.ack)
        else $error("misaligned store not faulted");
    a_mm_answer: assert property (ce_i && mm_req_i.valid && mm_req_i.size == SIZE_WORD
        && mm_req_i.addr[1:0] == 2'h0 |=> mm_rsp_o.ack && !mm_rsp_o.load_fault
        && !mm_rsp_o.store_fault) else $error("word access not acked");
    a_csr_answer: assert property (ce_i && csr_req_i.valid |=> csr_rsp_o.ack)
        else $error("csr access not acked");
    a_cfg_reserved: assert property (ce_i && mm_req_i.valid && !mm_req_i.write
        && mm_req_i.addr == OFS_CFG && mm_req_i.size == SIZE_WORD
        |=> mm_rsp_o.rdata[31:1] == 31'h0) else $error("config reserved bits set");
endmodule : pnc_checker

bind pnc_core pnc_checker #(.source_count_param(source_count_param)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .mm_req_i(mm_req_i), .mm_rsp_o(mm_rsp_o),
    .csr_req_i(csr_req_i), .csr_rsp_o(csr_rsp_o), .take_i(take_i), .mret_i(mret_i),
    .mie_o(mie_o), .ext_pend_o(ext_pend_o), .ext_irq_o(ext_irq_o));

// [sim/pnc_src_model.sv]
`timescale 1ns/1ns
module pnc_src_model #(
    parameter int n_src = 4 // sources modelled
) (
    input  wire logic           clk_i,  // clock
    input  wire logic           rst_i,  // reset
    input  wire logic [n_src:1] want_i, // levels asked by bench
    output logic      [n_src:1] req_o   // request levels
);
    // ip drives its level from its own flop, so one cycle late
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_o <= '0;
        end else begin
            req_o <= want_i;
        end
    end
endmodule : pnc_src_model

// [sim/testbench.sv]
`timescale 1ns/1ns
module testbench;
    import pnc_pkg::*;
    logic         clk_i, rst_i, take_i, mret_i, mie_wr_i, mie_wd, mie_o, ext_pend_o, ext_irq_o;
    logic [4:1]   want, src;
    pnc_mm_req_t  mm_req;
    pnc_mm_rsp_t  mr, mm_rsp;
    pnc_csr_req_t csr_req;
    pnc_csr_rsp_t csr_rsp;
    int           error_cnt = 0, n_checks = 0, cyc = 0;
    pnc_src_model #(.n_src(4)) u_src (.clk_i(clk_i), .rst_i(rst_i), .want_i(want), .req_o(src));
    pnc_core #(.source_count_param(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .src_req_i(src), .mm_req_i(mm_req), .mm_rsp_o(mm_rsp), .csr_req_i(csr_req),
        .csr_rsp_o(csr_rsp), .take_i(take_i), .mret_i(mret_i), .mie_wr_i(mie_wr_i),
        .mie_wdata_i(mie_wd), .mie_o(mie_o), .ext_pend_o(ext_pend_o), .ext_irq_o(ext_irq_o));
    initial begin
        clk_i = 0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    // one access: request held until the taking edge, answer read next cycle
    task automatic mm(input logic w, input logic [14:0] a, input logic [31:0] d,
                      input logic [1:0] sz);
        @(posedge clk_i);
        mm_req <= '{1'b1, w, a, sz, d};
        @(posedge clk_i);
        mm_req.valid <= 1'b0;
        @(negedge clk_i);
        mr = mm_rsp;
    endtask : mm
    task automatic rdchk(input string nm, input logic [14:0] a, input logic [31:0] exp);
        mm(1'b0, a, 32'h0, SIZE_WORD);
        chk({nm, "_ack"}, 32'(mr.ack), 32'h0000_0001);
        chk(nm, mr.rdata, exp);
    endtask : rdchk
    task automatic csr(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        csr_req <= '{1'b1, w, a, d};
        @(posedge clk_i);
        csr_req.valid <= 1'b0;
        @(negedge clk_i);
    endtask : csr
    task automatic hart(input logic t, input logic m, input logic w, input logic v);
        @(posedge clk_i);
        {take_i, mret_i, mie_wr_i, mie_wd} <= {t, m, w, v};
        @(posedge clk_i);
        {take_i, mret_i, mie_wr_i} <= 3'b000;
        @(negedge clk_i);
    endtask : hart
    // margin over the four cycle request path
    task automatic settle(input string nm, input logic exp);
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        chk(nm, 32'(ext_pend_o), 32'(exp));
    endtask : settle
    // hang guard, well above the sequence length
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            stop_test();
        end
    end
    initial begin
        rst_i = 1'b1;
        mm_req = '0;
        csr_req = '0;
        want = '0;
        {take_i, mret_i, mie_wr_i, mie_wd} = 4'h0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("cfg", OFS_CFG, 32'h0000_0000);
        mm(1'b1, 15'h0004, 32'hFFFF_FFF5, SIZE_WORD);
        rdchk("prio1", 15'h0004, 32'h0000_0005);
        mm(1'b1, 15'h0000, 32'h0000_000F, SIZE_WORD);
        rdchk("prio0", 15'h0000, 32'h0000_0000);
        mm(1'b1, 15'h0014, 32'h0000_000F, SIZE_WORD);
        rdchk("prio5", 15'h0014, 32'h0000_0000);
        mm(1'b1, 15'h7000, 32'h0000_0001, SIZE_WORD);
        rdchk("unmapped", 15'h7000, 32'h0000_0000);
        mm(1'b0, 15'h0004, 32'h0, 2'h0);
        chk("ldflt", 32'(mr.load_fault), 32'h0000_0001);
        mm(1'b1, 15'h0006, 32'h0, SIZE_WORD);
        chk("stflt", 32'(mr.store_fault), 32'h0000_0001);
        rdchk("prio1", 15'h0004, 32'h0000_0005);
        mm(1'b1, OFS_CFG, 32'hFFFF_FFFF, SIZE_WORD);
        rdchk("cfg", OFS_CFG, 32'h0000_0001);
        mm(1'b1, 15'h0008, 32'h0000_0003, SIZE_WORD);
        rdchk("prio2r", 15'h0008, 32'h0000_0003);
        csr(1'b1, CSR_THRESH, 32'h0000_000E);
        mm(1'b1, OFS_CFG, 32'h0000_0000, SIZE_WORD);
        rdchk("prio2", 15'h0008, 32'h0000_000C);
        csr(1'b0, CSR_THRESH, 32'h0);
        chk("thr", csr_rsp.rdata, 32'h0000_0001);
        csr(1'b1, CSR_THRESH, 32'h0);
        for (int i = 1; i <= 3; i++) mm(1'b1, 15'(32'h2000 + 4 * i), 32'h1, SIZE_WORD);
        rdchk("en1", 15'h2004, 32'h0000_0001);
        mm(1'b1, 15'h000C, 32'h0000_000C, SIZE_WORD);
        hart(1'b0, 1'b0, 1'b1, 1'b1);
        @(posedge clk_i);
        want <= 4'b0110;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        chk("pend_early", 32'(ext_pend_o), 32'h0);
        @(negedge clk_i);
        chk("pend", 32'(ext_pend_o), 32'h1);
        chk("irq", 32'(ext_irq_o), 32'h1);
        rdchk("pendw0", OFS_PEND, 32'h0000_000C);
        csr(1'b1, CSR_CAPTURE, 32'h0);
        csr(1'b0, CSR_CLPRIO, 32'h0);
        chk("clprio", csr_rsp.rdata, 32'h0000_000C);
        csr(1'b0, CSR_HPTR, 32'h0);
        chk("hptr", csr_rsp.rdata, 32'h0000_0008);
        csr(1'b1, CSR_VBASE, 32'hFFFF_FFFF);
        csr(1'b0, CSR_HPTR, 32'h0);
        chk("hptr_base", csr_rsp.rdata, 32'hFFFF_FC08);
        csr(1'b1, CSR_THRESH, 32'h0000_000C);
        settle("thr_eq", 1'b0);
        csr(1'b1, CSR_THRESH, 32'h0000_0000);
        csr(1'b1, CSR_CURPRIO, 32'h0000_000C);
        settle("cur_eq", 1'b0);
        csr(1'b1, CSR_CURPRIO, 32'h0000_000B);
        settle("preempt", 1'b1);
        csr(1'b0, CSR_CURPRIO, 32'h0);
        chk("cur", csr_rsp.rdata, 32'h0000_000B);
        // take then return, one quiet cycle apart, so the restore property fires
        hart(1'b1, 1'b0, 1'b0, 1'b0);
        chk("take", 32'(mie_o), 32'h0);
        hart(1'b0, 1'b1, 1'b0, 1'b0);
        chk("mret", 32'(mie_o), 32'h1);
        chk("irq_back", 32'(ext_irq_o), 32'h1);
        // software clears the enable: the request must drop while still pending
        hart(1'b0, 1'b0, 1'b1, 1'b0);
        chk("irq_off", 32'(ext_irq_o), 32'h0);
        chk("pend_kept", 32'(ext_pend_o), 32'h1);
        stop_test();
    end
endmodule : testbench
